// ==== core/mie_pkg.sv ====
package mie_pkg;
   // Datapath widths
   localparam int DATA_W = 8;
   localparam int PTR_W = 16;
   localparam int BANK_W = 5;
   localparam int PAGE_W = 7;
   localparam int FILE_W = 7;
   localparam int OFS_W = 6;
   localparam int INSTR_W = 14;
   localparam int REG_AW = 3;
   localparam int REG_DW = 16;
   // Opcode patterns and masks
   localparam logic [13:0] OPC_LDI_UPD = 14'h0010;
   localparam logic [13:0] MSK_LDI_UPD = 14'h3FF8;
   localparam logic [13:0] OPC_LDI_OFS = 14'h3F00;
   localparam logic [13:0] MSK_LDI_OFS = 14'h3F80;
   localparam logic [13:0] OPC_LDB = 14'h0020;
   localparam logic [13:0] MSK_LDB = 14'h3FE0;
   localparam logic [13:0] OPC_LDP = 14'h3180;
   localparam logic [13:0] MSK_LDP = 14'h3F80;
   localparam logic [13:0] OPC_LDA = 14'h3000;
   localparam logic [13:0] MSK_LDA = 14'h3C00;
   localparam logic [13:0] OPC_STA = 14'h0080;
   localparam logic [13:0] MSK_STA = 14'h3F80;
   // Field positions
   localparam int SEL_BIT_UPD = 2;
   localparam int SEL_BIT_OFS = 6;
   // Pointer update codes
   localparam logic [1:0] UPD_PRE_INC = 2'h0;
   localparam logic [1:0] UPD_PRE_DEC = 2'h1;
   localparam logic [1:0] UPD_POST_INC = 2'h2;
   localparam logic [1:0] UPD_POST_DEC = 2'h3;
   // File addresses that alias the indirect access ports
   localparam logic [6:0] IND_PORT0_F = 7'h00;
   localparam logic [6:0] IND_PORT1_F = 7'h01;
   // Register port offsets
   localparam logic [2:0] REG_ACC = 3'h0;
   localparam logic [2:0] REG_BANK = 3'h1;
   localparam logic [2:0] REG_PAGE = 3'h2;
   localparam logic [2:0] REG_PTR0 = 3'h3;
   localparam logic [2:0] REG_PTR1 = 3'h4;
   localparam logic [2:0] REG_STATUS = 3'h5;
   // Reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [4:0] BANK_RST = 5'h00;
   localparam logic [6:0] PAGE_RST = 7'h00;
   localparam logic [15:0] PTR_RST = 16'h0000;
   // Decoded operation
   typedef enum logic [2:0] {
      OP_NONE, OP_LDI_UPD, OP_LDI_OFS, OP_LDB, OP_LDP, OP_LDA, OP_STA
   } mie_op_t;
endpackage

// ==== core/mie_decode.sv ====
module mie_decode (
   input wire logic [mie_pkg::INSTR_W-1:0] i_instr, // Instruction word
   output mie_pkg::mie_op_t o_op, // Decoded operation
   output logic o_sel, // Pointer select
   output logic [1:0] o_code, // Pointer update code
   output logic [mie_pkg::OFS_W-1:0] o_ofs, // Signed offset
   output logic [mie_pkg::DATA_W-1:0] o_lit, // Literal field
   output logic [mie_pkg::FILE_W-1:0] o_file // File address
);
   import mie_pkg::*;

   // Fields are sliced unconditionally; the op says which ones matter
   assign o_code = i_instr[1:0];
   assign o_ofs = i_instr[OFS_W-1:0];
   assign o_lit = i_instr[DATA_W-1:0];
   assign o_file = i_instr[FILE_W-1:0];

   // Match each pattern under its mask
   always_comb begin
      o_op = OP_NONE;
      o_sel = 1'b0;
      if ((i_instr & MSK_LDI_UPD) == OPC_LDI_UPD) begin
         o_op = OP_LDI_UPD;
         o_sel = i_instr[SEL_BIT_UPD];
      end else if ((i_instr & MSK_LDI_OFS) == OPC_LDI_OFS) begin
         o_op = OP_LDI_OFS;
         o_sel = i_instr[SEL_BIT_OFS];
      end else if ((i_instr & MSK_LDB) == OPC_LDB) begin
         o_op = OP_LDB;
      end else if ((i_instr & MSK_LDP) == OPC_LDP) begin
         o_op = OP_LDP;
      end else if ((i_instr & MSK_LDA) == OPC_LDA) begin
         // Filler bits are masked out, so the cleared form decodes
         o_op = OP_LDA;
      end else if ((i_instr & MSK_STA) == OPC_STA) begin
         o_op = OP_STA;
      end
   end
endmodule

// ==== core/mie_ptr.sv ====
module mie_ptr #(
   parameter int W = mie_pkg::PTR_W
) (
   input wire logic i_clk, // Clock
   input wire logic i_rst, // Async reset
   input wire logic i_upd, // Indirect load uses this pointer
   input wire logic i_ofs_mode, // Relative offset form
   input wire logic [1:0] i_code, // Update code
   input wire logic [mie_pkg::OFS_W-1:0] i_ofs, // Signed offset
   input wire logic i_wr, // Software write
   input wire logic [W-1:0] i_wdata, // Software write data
   output logic [W-1:0] o_ptr, // Pointer value
   output logic [W-1:0] o_ea // Effective address
);
   import mie_pkg::*;

   // A pointer narrower than the offset field could not reach both offset limits
   if (W < OFS_W) begin : g_bad_width
      $error("mie_ptr: W below offset width");
   end

   logic [W-1:0] ptr_reg;
   logic [W-1:0] ptr_next;
   logic [W-1:0] ofs_ext; // Sign-extended offset

   assign ofs_ext = W'($signed(i_ofs));
   assign o_ptr = ptr_reg;

   // Effective address; sums drop the carry so the range wraps
   always_comb begin
      case (i_code)
         UPD_PRE_INC: o_ea = ptr_reg + W'(1);
         UPD_PRE_DEC: o_ea = ptr_reg - W'(1);
         default: o_ea = ptr_reg;
      endcase
      if (i_ofs_mode) begin
         o_ea = ptr_reg + ofs_ext;
      end
   end

   // Pointer step after the move; bit 0 of the code picks the direction
   always_comb begin
      if (i_ofs_mode) begin
         ptr_next = ptr_reg;
      end else if (i_code[0]) begin
         ptr_next = ptr_reg - W'(1);
      end else begin
         ptr_next = ptr_reg + W'(1);
      end
   end

   // Instruction update wins over a software write in the same cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ptr_reg <= W'(PTR_RST);
      end else if (i_upd) begin
         ptr_reg <= ptr_next;
      end else if (i_wr) begin
         ptr_reg <= i_wdata;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_ptr_step: assert property (i_upd && !i_ofs_mode |=>
      o_ptr == ($past(i_code[0]) ? $past(o_ptr) - W'(1) : $past(o_ptr) + W'(1)))
      else $error("pointer did not step by one");
   a_ptr_ofs_hold: assert property (i_upd && i_ofs_mode |=> $stable(o_ptr))
      else $error("offset form changed the pointer");
endmodule

// ==== core/mie_core.sv ====
module mie_core #(
   parameter int PTR_W = mie_pkg::PTR_W
) (
   input wire logic i_clk, // 100 MHz clock
   input wire logic i_rst, // Async reset, active high
   input wire logic [mie_pkg::INSTR_W-1:0] i_instr, // Instruction word
   input wire logic i_instr_valid, // Instruction offered
   output logic o_instr_ready, // Core can take an instruction
   output logic [PTR_W-1:0] o_mem_addr, // Data memory address
   output logic o_mem_rd, // Memory read pulse
   output logic o_mem_wr, // Memory write pulse
   output logic [mie_pkg::DATA_W-1:0] o_mem_wdata, // Memory write data
   input wire logic [mie_pkg::DATA_W-1:0] i_mem_rdata, // Read data, cycle after o_mem_rd
   output logic [mie_pkg::DATA_W-1:0] o_acc, // Accumulator
   output logic [mie_pkg::BANK_W-1:0] o_bank, // Bank select latch
   output logic [mie_pkg::PAGE_W-1:0] o_page, // Program counter high latch
   output logic o_zero, // Null-result flag
   input wire logic [mie_pkg::REG_AW-1:0] i_reg_addr, // Register port address
   input wire logic [mie_pkg::REG_DW-1:0] i_reg_wdata, // Register write data
   input wire logic i_reg_wr, // Register write strobe
   input wire logic i_reg_rd, // Register read strobe
   output logic [mie_pkg::REG_DW-1:0] o_reg_rdata // Read data, cycle after strobe
);
   import mie_pkg::*;

   // The store address must fit inside a pointer-wide address bus
   // Twelve bits hold bank and operand; the register port caps it at sixteen
   if (PTR_W < BANK_W + FILE_W || PTR_W > REG_DW) begin : g_bad_width
      $error("mie_core: PTR_W out of range");
   end

   // Load sequence states
   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_CAPTURE} mie_state_t;

   mie_state_t state_reg; // Load sequence state
   mie_state_t state_next; // Next load state

   // Decoder fields
   mie_op_t op; // Decoded operation
   logic sel; // Pointer select
   logic [1:0] code; // Pointer update code
   logic [OFS_W-1:0] ofs; // Signed offset field
   logic [DATA_W-1:0] lit; // Literal field
   logic [FILE_W-1:0] file; // File address field
   logic accept; // Instruction taken this cycle
   logic is_ldi; // Either indirect load form

   // Pointer slices
   logic [PTR_W-1:0] ptr [2]; // Pointer values
   logic [PTR_W-1:0] ea [2]; // Effective addresses
   logic [PTR_W-1:0] sta_addr; // Store target after redirect

   // Architectural state seen by software
   logic [DATA_W-1:0] acc_reg; // Accumulator
   logic [BANK_W-1:0] bank_reg; // Bank select latch
   logic [PAGE_W-1:0] page_reg; // Page latch
   logic zero_reg; // Null-result flag

   // Memory request, registered so the far side sees clean pulses
   logic [PTR_W-1:0] addr_reg; // Memory address
   logic rd_reg; // Read pulse
   logic wr_reg; // Write pulse
   logic [DATA_W-1:0] wdata_reg; // Write data

   // Register port
   logic [REG_DW-1:0] rdata_reg; // Register port read data
   logic [REG_DW-1:0] rdata_next; // Register port read mux

   // Pure decode, no state; fields are valid whenever the word is
   mie_decode u_decode (
      .i_instr(i_instr),
      .o_op(op),
      .o_sel(sel),
      .o_code(code),
      .o_ofs(ofs),
      .o_lit(lit),
      .o_file(file)
   );

   // A load holds off new instructions until its data is captured
   assign o_instr_ready = (state_reg == ST_IDLE);
   assign accept = i_instr_valid && o_instr_ready;
   assign is_ldi = (op == OP_LDI_UPD) || (op == OP_LDI_OFS);

   // One pointer slice per indirect port
   // Both slices see the same code; only the selected one is enabled
   for (genvar g = 0; g < 2; g++) begin : g_ptr
      mie_ptr #(
         .W(PTR_W)
      ) u_ptr (
         .i_clk(i_clk),
         .i_rst(i_rst),
         .i_upd(accept && is_ldi && (sel == 1'(g))),
         .i_ofs_mode(op == OP_LDI_OFS),
         .i_code(code),
         .i_ofs(ofs),
         .i_wr(i_reg_wr && (i_reg_addr == REG_PTR0 + 3'(g))),
         .i_wdata(i_reg_wdata[PTR_W-1:0]),
         .o_ptr(ptr[g]),
         .o_ea(ea[g])
      );
   end

   // Store target: bank and operand, unless it names an indirect port
   always_comb begin
      sta_addr = PTR_W'({bank_reg, file});
      // Ports 0 and 1 are not storage; the pointer names the real byte
      if (file == IND_PORT0_F) begin
         sta_addr = ptr[0];
      end else if (file == IND_PORT1_F) begin
         sta_addr = ptr[1];
      end
   end

   // Load sequence: issue read, then capture the returned byte
   // Ready stays low in issue and capture, which is the two-cycle gap
   always_comb begin
      case (state_reg)
         ST_IDLE: state_next = (accept && is_ldi) ? ST_ISSUE : ST_IDLE;
         ST_ISSUE: state_next = ST_CAPTURE;
         ST_CAPTURE: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   // State register; a load always runs the same three steps
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Memory request; the effective address is sampled before the pointer moves
   // Write data is the accumulator as it stands at the taking edge
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         addr_reg <= '0;
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         wdata_reg <= '0;
      end else begin
         rd_reg <= accept && is_ldi;
         wr_reg <= accept && (op == OP_STA);
         if (accept && is_ldi) begin
            addr_reg <= ea[sel];
         end else if (accept && (op == OP_STA)) begin
            addr_reg <= sta_addr;
            wdata_reg <= acc_reg;
         end
      end
   end

   // Accumulator: captured byte, literal, then software write
   // Software loses to an instruction in the same cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         acc_reg <= ACC_RST;
      end else if (state_reg == ST_CAPTURE) begin
         acc_reg <= i_mem_rdata;
      end else if (accept && (op == OP_LDA)) begin
         acc_reg <= lit;
      end else if (i_reg_wr && (i_reg_addr == REG_ACC)) begin
         acc_reg <= i_reg_wdata[DATA_W-1:0];
      end
   end

   // Zero flag moves only with an indirect load; the literal moves leave it
   // Software has no write path to the flag, so only memory data sets it
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         zero_reg <= 1'b0;
      end else if (state_reg == ST_CAPTURE) begin
         zero_reg <= (i_mem_rdata == 8'h00);
      end
   end

   // Bank latch takes the full five-bit field, range check is software's
   // An instruction outranks a same-cycle software write
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         bank_reg <= BANK_RST;
      end else if (accept && (op == OP_LDB)) begin
         bank_reg <= lit[BANK_W-1:0];
      end else if (i_reg_wr && (i_reg_addr == REG_BANK)) begin
         bank_reg <= i_reg_wdata[BANK_W-1:0];
      end
   end

   // Page latch
   // Same priority order as the bank latch
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         page_reg <= PAGE_RST;
      end else if (accept && (op == OP_LDP)) begin
         page_reg <= lit[PAGE_W-1:0];
      end else if (i_reg_wr && (i_reg_addr == REG_PAGE)) begin
         page_reg <= i_reg_wdata[PAGE_W-1:0];
      end
   end

   // Register port read mux; unmapped offsets read zero
   // Status packs busy above the flag so polling needs one read
   always_comb begin
      rdata_next = '0;
      case (i_reg_addr)
         REG_ACC: rdata_next = REG_DW'(acc_reg);
         REG_BANK: rdata_next = REG_DW'(bank_reg);
         REG_PAGE: rdata_next = REG_DW'(page_reg);
         REG_PTR0: rdata_next = REG_DW'(ptr[0]);
         REG_PTR1: rdata_next = REG_DW'(ptr[1]);
         REG_STATUS: rdata_next = REG_DW'({!o_instr_ready, zero_reg});
         default: rdata_next = '0;
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_reg <= '0;
      end else if (i_reg_rd) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= '0;
      end
   end

   // Outputs other than o_instr_ready come straight from registers, so they never glitch
   assign o_mem_addr = addr_reg;
   assign o_mem_rd = rd_reg;
   assign o_mem_wr = wr_reg;
   assign o_mem_wdata = wdata_reg;
   assign o_acc = acc_reg;
   assign o_bank = bank_reg;
   assign o_page = page_reg;
   assign o_zero = zero_reg;
   assign o_reg_rdata = rdata_reg;

   // Checks run on the core clock and rest while reset is high
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // Instruction-port checks
   sequence s_ldi_start;
      accept && is_ldi;
   endsequence

   sequence s_ldi_read;
      o_mem_rd && !o_instr_ready ##1 (state_reg == ST_CAPTURE) && !o_instr_ready;
   endsequence

   a_ldi_flow: assert property (s_ldi_start |=> s_ldi_read ##1
      (o_acc == $past(i_mem_rdata) && o_zero == (o_acc == 8'h00) && o_instr_ready))
      else $error("indirect load did not deliver the byte");
   a_ldi_address: assert property (s_ldi_start |=> o_mem_addr == $past(ea[sel]))
      else $error("indirect read address wrong");
   a_ofs_address: assert property (accept && op == OP_LDI_OFS |=>
      o_mem_addr == $past(ptr[sel]) + PTR_W'($signed($past(ofs))))
      else $error("offset address wrong");
   a_bank_load: assert property (accept && op == OP_LDB |=>
      o_bank == $past(lit[BANK_W-1:0]) && $stable(o_zero))
      else $error("bank literal not loaded");
   a_page_load: assert property (accept && op == OP_LDP |=>
      o_page == $past(lit[PAGE_W-1:0]) && $stable(o_zero) && o_instr_ready)
      else $error("page literal not loaded");
   a_acc_literal: assert property (accept && op == OP_LDA |=>
      o_acc == $past(lit) && $stable(o_zero) && o_instr_ready)
      else $error("accumulator literal not loaded");
   // Store checks
   a_store_write: assert property (accept && op == OP_STA && file > IND_PORT1_F |=>
      o_mem_wr && o_mem_wdata == $past(o_acc) && $stable(o_zero)
      && o_mem_addr == PTR_W'({$past(o_bank), $past(file)}))
      else $error("store wrote the wrong place or value");
   a_store_redirect: assert property (accept && op == OP_STA && file == IND_PORT1_F |=>
      o_mem_wr && o_mem_addr == $past(ptr[1]))
      else $error("store to indirect port not redirected");
   a_store_port0: assert property (accept && op == OP_STA && file == IND_PORT0_F |=>
      o_mem_wr && o_mem_addr == $past(ptr[0]))
      else $error("store to indirect port 0 not redirected");

   // Two refused cycles while the read is out and the byte comes back
   sequence s_busy_gap;
      !o_instr_ready ##1 !o_instr_ready;
   endsequence

   // Load pacing and flag checks
   a_load_gap: assert property (s_ldi_start |=> s_busy_gap ##1 o_instr_ready)
      else $error("load did not hold off instructions for two cycles");
   a_rd_pulse: assert property (o_mem_rd |=> !o_mem_rd)
      else $error("memory read longer than one cycle");
   a_flag_hold: assert property (
      state_reg != ST_CAPTURE |=> $stable(o_zero))
      else $error("null-result flag moved outside a load");
endmodule

// ==== testbench/mie_mem_model.sv ====
module mie_mem_model (
   input wire logic i_clk, // Core clock
   input wire logic [15:0] i_addr, // Memory address from core
   input wire logic i_rd, // Read pulse
   input wire logic i_wr, // Write pulse
   input wire logic [7:0] i_wdata, // Write data
   output logic [7:0] o_rdata // Read data, one cycle after read pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   // Sparse store; untouched bytes follow a fixed address pattern
   logic [7:0] mem [logic [15:0]];

   // Current content of one byte, also used by the bench for expectations
   function automatic logic [7:0] peek(input logic [15:0] a);
      if (mem.exists(a)) begin
         return mem[a];
      end
      return a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction

   initial begin
      o_rdata = 8'h00;
   end

   // Data stands only in the cycle after the read; otherwise it toggles
   // so a late capture by the core cannot hit the right value by luck
   always @(posedge i_clk) begin
      if (i_wr) begin
         mem[i_addr] = i_wdata;
      end
      if (i_rd) begin
         o_rdata <= peek(i_addr);
      end else begin
         o_rdata <= ~o_rdata;
      end
   end
endmodule

// ==== testbench/test_move_instruction_execute.sv ====
module test_move_instruction_execute;
   timeunit 1ns;
   timeprecision 1ps;
   import mie_pkg::*;
   logic i_clk = 1'b0; // Core clock
   logic i_rst = 1'b1; // Reset, active high
   logic [13:0] i_instr = 14'h0000; // Instruction word
   logic i_instr_valid = 1'b0; // Instruction offered
   logic [2:0] i_reg_addr = 3'h0; // Register address
   logic [15:0] i_reg_wdata = 16'h0000; // Register write data
   logic i_reg_wr = 1'b0; // Register write strobe
   logic i_reg_rd = 1'b0; // Register read strobe
   logic o_instr_ready, o_mem_rd, o_mem_wr, o_zero;
   logic [15:0] o_mem_addr, o_reg_rdata;
   logic [7:0] o_mem_wdata, i_mem_rdata, o_acc;
   logic [4:0] o_bank;
   logic [6:0] o_page;
   int mismatches = 0; // Failed comparisons
   int checks = 0; // All comparisons

   mie_core u_mie_core (.i_clk(i_clk), .i_rst(i_rst), .i_instr(i_instr),
      .i_instr_valid(i_instr_valid), .o_instr_ready(o_instr_ready),
      .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
      .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .o_acc(o_acc),
      .o_bank(o_bank), .o_page(o_page), .o_zero(o_zero), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .o_reg_rdata(o_reg_rdata));
   mie_mem_model u_mem (.i_clk(i_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd),
      .i_wr(o_mem_wr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

   // 100 MHz clock
   always #5 i_clk = ~i_clk;

   // Compare and count; narrow values arrive zero extended
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One-cycle register write, entered just after a rising edge
   task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask

   // One-cycle register read; data checked in the following cycle only
   task automatic reg_chk(input string name, input logic [2:0] a, input logic [15:0] exp);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      @(negedge i_clk);
      check(name, o_reg_rdata, exp);
      @(posedge i_clk);
   endtask

   // Offer one instruction; valid is held when another follows at once
   task automatic exec(input logic [13:0] ins, input logic last);
      i_instr <= ins;
      i_instr_valid <= 1'b1;
      @(negedge i_clk);
      check("ready", o_instr_ready, 1'b1);
      @(posedge i_clk);
      if (last) begin
         i_instr_valid <= 1'b0;
      end
   endtask

   // Register defaults, unmapped place and one-cycle read data
   task automatic t_reset();
      for (int a = 0; a < 8; a++) begin
         reg_chk("reset reg", a[2:0], 16'h0000);
      end
      reg_wr(3'h6, 16'hFFFF);
      reg_chk("unmapped", 3'h6, 16'h0000);
      @(negedge i_clk);
      check("rdata idle", o_reg_rdata, 16'h0000);
      @(posedge i_clk);
   endtask

   // Stores through bank plus operand, then through a pointer port
   task automatic t_store();
      exec(OPC_LDA | 14'h004F, 1'b0);
      exec(OPC_LDB | 14'h0003, 1'b0);
      exec(OPC_STA | 14'h0025, 1'b1);
      @(negedge i_clk);
      check("st wr", o_mem_wr, 1'b1);
      check("st addr", o_mem_addr, 16'h01A5);
      check("st data", o_mem_wdata, 8'h4F);
      check("st zero", o_zero, 1'b0);
      @(negedge i_clk);
      check("st end", o_mem_wr, 1'b0);
      check("st mem", u_mem.peek(16'h01A5), 8'h4F);
      @(posedge i_clk);
      reg_wr(REG_PTR1, 16'h0300);
      exec(OPC_LDA | 14'h0000, 1'b0);
      exec(OPC_STA | 14'h0001, 1'b1);
      @(negedge i_clk);
      check("port addr", o_mem_addr, 16'h0300);
      check("port wr", o_mem_wr, 1'b1);
      @(posedge i_clk);
   endtask

   // One indirect load: address, capture, flag and pointer afterwards
   task automatic ind_case(input logic sel, input logic ofs, input logic [1:0] code,
         input logic [5:0] k, input logic [15:0] p, input logic [15:0] ea,
         input logic [15:0] pn);
      logic [7:0] d;
      logic [2:0] ra;
      ra = sel ? REG_PTR1 : REG_PTR0;
      d = u_mem.peek(ea);
      reg_wr(ra, p);
      exec(ofs ? (OPC_LDI_OFS | {7'h00, sel, k}) : (OPC_LDI_UPD | {11'h000, sel, code}), 1'b1);
      @(negedge i_clk);
      check("ind rd", o_mem_rd, 1'b1);
      check("ind ea", o_mem_addr, ea);
      check("ind busy", o_instr_ready, 1'b0);
      @(negedge i_clk);
      @(negedge i_clk);
      check("ind acc", o_acc, d);
      check("ind zero", o_zero, d == 8'h00);
      @(posedge i_clk);
      reg_chk("ptr after", ra, pn);
   endtask

   // Every update code, both offset limits, wrap both ways, a zero byte
   task automatic t_indirect();
      ind_case(1'b0, 1'b0, 2'h0, 6'h00, 16'hFFFF, 16'h0000, 16'h0000);
      ind_case(1'b1, 1'b0, 2'h1, 6'h00, 16'h0000, 16'hFFFF, 16'hFFFF);
      ind_case(1'b0, 1'b0, 2'h2, 6'h00, 16'h1234, 16'h1234, 16'h1235);
      ind_case(1'b1, 1'b0, 2'h3, 6'h00, 16'h0000, 16'h0000, 16'hFFFF);
      ind_case(1'b0, 1'b1, 2'h0, 6'h20, 16'h0010, 16'hFFF0, 16'h0010);
      ind_case(1'b1, 1'b1, 2'h0, 6'h1F, 16'h0010, 16'h002F, 16'h0010);
      ind_case(1'b1, 1'b0, 2'h2, 6'h00, 16'h0300, 16'h0300, 16'h0301);
   endtask

   // Back-to-back literal moves leave the set flag alone
   task automatic t_literal();
      exec(OPC_LDA | 14'h035A, 1'b0);
      exec(OPC_LDB | 14'h000F, 1'b0);
      exec(OPC_LDP | 14'h007F, 1'b1);
      @(negedge i_clk);
      check("acc", o_acc, 8'h5A);
      check("bank", o_bank, 5'h0F);
      check("page", o_page, 7'h7F);
      check("flag kept", o_zero, 1'b1);
      @(posedge i_clk);
      exec(OPC_LDA | 14'h00A5, 1'b0);
      exec(OPC_LDB | 14'h0000, 1'b0);
      exec(OPC_LDP | 14'h0000, 1'b1);
      @(negedge i_clk);
      check("acc clr", o_acc, 8'hA5);
      check("bank clr", o_bank, 5'h00);
      check("page clr", o_page, 7'h00);
      check("flag kept", o_zero, 1'b1);
      @(posedge i_clk);
      reg_chk("acc reg", REG_ACC, 16'h00A5);
   endtask

   // Bank write loses to an instruction, page and acc writes, port 0 store, busy status, ignored word
   task automatic t_regport();
      i_reg_addr <= REG_BANK;
      i_reg_wdata <= 16'h001F;
      i_reg_wr <= 1'b1;
      exec(OPC_LDB | 14'h0009, 1'b1);
      i_reg_wr <= 1'b0;
      reg_chk("bank wins", REG_BANK, 16'h0009);
      reg_wr(REG_PAGE, 16'h0042);
      reg_chk("page sw", REG_PAGE, 16'h0042);
      reg_wr(REG_ACC, 16'h0077);
      reg_chk("acc sw", REG_ACC, 16'h0077);
      reg_wr(REG_PTR0, 16'h0450);
      exec(OPC_STA | 14'h0000, 1'b1);
      @(negedge i_clk);
      check("port0 addr", o_mem_addr, 16'h0450);
      check("port0 wr", o_mem_wr, 1'b1);
      check("port0 data", o_mem_wdata, 8'h77);
      @(posedge i_clk);
      exec(OPC_LDI_UPD | 14'h0002, 1'b1);
      reg_chk("busy", REG_STATUS, 16'h0003);
      reg_chk("idle", REG_STATUS, 16'h0000);
      @(negedge i_clk);
      check("acc ld", o_acc, 8'h77);
      @(posedge i_clk);
      reg_chk("ptr0 step", REG_PTR0, 16'h0451);
      exec(14'h3FFF, 1'b1);
      @(negedge i_clk);
      check("none mem", {o_mem_rd, o_mem_wr}, 2'h0);
      check("none keep", {o_acc, 3'h0, o_bank}, 16'h7709);
      @(posedge i_clk);
   endtask

   // Cuts a hang short; the whole run needs well under this span
   initial begin
      repeat (5000) @(posedge i_clk);
      mismatches++;
      complete_run();
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      t_reset();
      t_store();
      t_indirect();
      t_literal();
      t_regport();
      complete_run();
   end
endmodule
